/* hdl/tcs_regs.svh */
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH


// Register offsets
`define TCS_OFS_CONTROL 8'h02
`define TCS_OFS_EVENT 8'h03
`define TCS_OFS_STATUS 8'h04

// Event register fields
`define TCS_EVT_RECOVER 7
`define TCS_EVT_OVERCUR 6
`define TCS_EVT_OVERVOLT 5
`define TCS_EVT_RSVD 4
`define TCS_EVT_OTP 3
`define TCS_EVT_FAULT 2
`define TCS_EVT_DETACH 1
`define TCS_EVT_ATTACH 0
`define TCS_EVT_LATCH_MASK 8'hEB

// Control register fields
`define TCS_CTRL_MASK 0

// Partner type codes
`define TCS_PARTNER_AUDIO 3'h3
`define TCS_PARTNER_DEBUG 3'h4

// Reset values
`define TCS_CONTROL_RESET 8'h00
`define TCS_EVENT_RESET 8'h00
`define TCS_STATUS_RESET 8'h00

// Serial bus slave address and bit count
`define TCS_I2C_ADDR 7'h1D
`define TCS_BITS_PER_BYTE 4'h8

`endif

/* hdl/tcs_pkg.sv */
package tcs_pkg;

    // Serial slave sequencer states
    typedef enum logic [8:0] {
        TCS_IDLE = 9'h001,
        TCS_ADDR = 9'h002,
        TCS_ADDR_ACK = 9'h004,
        TCS_REG = 9'h008,
        TCS_REG_ACK = 9'h010,
        TCS_WDATA = 9'h020,
        TCS_WDATA_ACK = 9'h040,
        TCS_RDATA = 9'h080,
        TCS_RACK = 9'h100
    } tcs_state_e;

    // Pin front-end state
    typedef struct packed {
        logic scl_meta;
        logic scl_sync;
        logic scl_prev;
        logic sda_meta;
        logic sda_sync;
        logic sda_prev;
    } tcs_pin_s;

    // Register and sequencer state
    typedef struct packed {
        tcs_state_e state;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic rw;
        logic nack;
        logic [7:0] ptr;
        logic sda_o;
        logic sda_oe;
        logic [7:0] control;
        logic [7:0] events;
        logic [7:0] status;
        logic [2:0] flt_prev;
        logic fault_d;
        logic attached_d;
        logic irq_o;
        logic irq_oe;
    } tcs_reg_s;

endpackage

/* hdl/tcs_i2c_pins.sv */
`timescale 1ns/10ps

module tcs_i2c_pins (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Raw bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    // Conditioned bus view
    output logic sda_sync,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_seen,
    output logic stop_seen
);

    tcs_pkg::tcs_pin_s s;
    tcs_pkg::tcs_pin_s next_s;

    // Two-stage synchronisers, then a third stage for edge detection
    always_comb begin
        next_s = s;
        next_s.scl_meta = scl_i;
        next_s.scl_sync = s.scl_meta;
        next_s.scl_prev = s.scl_sync;
        next_s.sda_meta = sda_i;
        next_s.sda_sync = s.sda_meta;
        next_s.sda_prev = s.sda_sync;
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '{scl_meta: 1'b1, scl_sync: 1'b1, scl_prev: 1'b1,
                   sda_meta: 1'b1, sda_sync: 1'b1, sda_prev: 1'b1};
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Edges and bus conditions, qualified by clock enable
    assign sda_sync = s.sda_sync;
    assign scl_rise = ce & s.scl_sync & ~s.scl_prev;
    assign scl_fall = ce & ~s.scl_sync & s.scl_prev;
    assign start_seen = ce & s.scl_sync & s.scl_prev & s.sda_prev & ~s.sda_sync;
    assign stop_seen = ce & s.scl_sync & s.scl_prev & ~s.sda_prev & s.sda_sync;

endmodule

/* hdl/tcs_event_status.sv */
`timescale 1ns/10ps
`include "tcs_regs.svh"

module tcs_event_status (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Serial register bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Open-drain interrupt pin
    output logic event_irq_n_o,
    output logic event_irq_n_oe,
    // VCONN fault conditions, levels
    input wire logic vconn_overcurrent_event,
    input wire logic vconn_overvoltage_event,
    input wire logic vconn_overtemp_event,
    // Connection state from the detection logic
    input wire logic port_attached,
    input wire logic role_is_sink,
    input wire logic vbus_present,
    input wire logic [1:0] adv_current,
    input wire logic [2:0] partner_type,
    input wire logic [1:0] plug_orient
);

    tcs_pkg::tcs_reg_s s;
    tcs_pkg::tcs_reg_s next_s;

    logic p_sda;
    logic p_rise;
    logic p_fall;
    logic p_start;
    logic p_stop;
    logic fault_live;
    logic sink_view;
    logic load_rd;
    logic rd_clr;
    logic byte_in;
    logic byte_done;
    logic [7:0] ev_set;
    logic [7:0] rd_byte;
    logic [7:0] event_view;
    logic [7:0] status_view;
    logic [2:0] fault_lvl;
    logic [2:0] fault_rise;

    // Power-on contents of every state field
    localparam tcs_pkg::tcs_reg_s reset_value = '{
        state: tcs_pkg::TCS_IDLE,
        cnt: 4'h0,
        shift: 8'h00,
        rw: 1'b0,
        nack: 1'b0,
        ptr: 8'h00,
        sda_o: 1'b0,
        sda_oe: 1'b0,
        control: `TCS_CONTROL_RESET,
        events: `TCS_EVENT_RESET,
        status: `TCS_STATUS_RESET,
        flt_prev: 3'h0,
        fault_d: 1'b0,
        attached_d: 1'b0,
        irq_o: 1'b0,
        irq_oe: 1'b0
    };

    // Pin conditioning
    tcs_i2c_pins u_pins (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_sync(p_sda),
        .scl_rise(p_rise),
        .scl_fall(p_fall),
        .start_seen(p_start),
        .stop_seen(p_stop)
    );

    // Event register as software sees it
    always_comb begin
        event_view = s.events & `TCS_EVT_LATCH_MASK;
        event_view[`TCS_EVT_FAULT] = s.fault_d;
        event_view[`TCS_EVT_RSVD] = 1'b0;
    end

    // Read data selection by register pointer
    always_comb begin
        case (s.ptr)
            `TCS_OFS_CONTROL: rd_byte = s.control;
            `TCS_OFS_EVENT: rd_byte = event_view;
            `TCS_OFS_STATUS: rd_byte = s.status;
            default: rd_byte = 8'h00;
        endcase
    end

    // Fault levels packed as over-current, over-voltage, over-temperature
    assign fault_lvl = {vconn_overcurrent_event, vconn_overvoltage_event, vconn_overtemp_event};

    // One rising-edge detector per fault level against last cycle's copy
    for (genvar g = 0; g < 3; g++) begin : g_fault_edge
        assign fault_rise[g] = fault_lvl[g] & ~s.flt_prev[g];
    end

    // Hardware event detection
    always_comb begin
        fault_live = |fault_lvl;
        ev_set = 8'h00;
        // Recovery only once the last fault is gone
        ev_set[`TCS_EVT_RECOVER] = s.fault_d & ~fault_live;
        ev_set[`TCS_EVT_OVERCUR] = fault_rise[2];
        ev_set[`TCS_EVT_OVERVOLT] = fault_rise[1];
        ev_set[`TCS_EVT_OTP] = fault_rise[0];
        // Attach and detach follow the edges of the attached level
        ev_set[`TCS_EVT_DETACH] = s.attached_d & ~port_attached;
        ev_set[`TCS_EVT_ATTACH] = ~s.attached_d & port_attached;
        sink_view = role_is_sink | (partner_type == `TCS_PARTNER_AUDIO)
                    | (partner_type == `TCS_PARTNER_DEBUG);
    end

    // Live connection status as it will be captured
    always_comb begin
        status_view = 8'h00;
        status_view[7] = vbus_present & sink_view;
        status_view[6:5] = role_is_sink ? adv_current : 2'h0;
        status_view[4:2] = partner_type;
        status_view[1:0] = plug_orient;
    end

    // Byte boundary helpers for the receive states
    assign byte_in = p_rise & (s.cnt != `TCS_BITS_PER_BYTE);
    assign byte_done = p_fall & (s.cnt == `TCS_BITS_PER_BYTE);

    // Next-state logic: serial slave, event latches, status capture
    always_comb begin
        next_s = s;
        load_rd = 1'b0;
        rd_clr = 1'b0;

        // Serial slave sequencer
        if (p_stop) begin
            next_s.state = tcs_pkg::TCS_IDLE;
            next_s.sda_oe = 1'b0;
        end else if (p_start) begin
            next_s.state = tcs_pkg::TCS_ADDR;
            next_s.cnt = 4'h0;
            next_s.sda_oe = 1'b0;
        end else begin
            case (s.state)
                // Idle: bus released, waiting for a start
                tcs_pkg::TCS_IDLE: begin
                    next_s.sda_oe = 1'b0;
                end

                // Address byte: shift in seven address bits and the direction bit
                tcs_pkg::TCS_ADDR: begin
                    if (byte_in) begin
                        next_s.shift = {s.shift[6:0], p_sda};
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (byte_done) begin
                        next_s.cnt = 4'h0;
                        // Our address is acknowledged; any other leaves the bus alone
                        if (s.shift[7:1] == `TCS_I2C_ADDR) begin
                            next_s.rw = s.shift[0];
                            next_s.sda_oe = 1'b1;
                            next_s.state = tcs_pkg::TCS_ADDR_ACK;
                        end else begin
                            next_s.state = tcs_pkg::TCS_IDLE;
                        end
                    end
                end

                // Pointer byte of a write transfer
                tcs_pkg::TCS_REG: begin
                    if (byte_in) begin
                        next_s.shift = {s.shift[6:0], p_sda};
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (byte_done) begin
                        next_s.cnt = 4'h0;
                        next_s.ptr = s.shift;
                        next_s.sda_oe = 1'b1;
                        next_s.state = tcs_pkg::TCS_REG_ACK;
                    end
                end

                // Data bytes of a write transfer
                tcs_pkg::TCS_WDATA: begin
                    if (byte_in) begin
                        next_s.shift = {s.shift[6:0], p_sda};
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (byte_done) begin
                        next_s.cnt = 4'h0;
                        // Only the control register takes writes
                        if (s.ptr == `TCS_OFS_CONTROL) begin
                            next_s.control = s.shift;
                        end
                        next_s.ptr = s.ptr + 8'h01;
                        next_s.sda_oe = 1'b1;
                        next_s.state = tcs_pkg::TCS_WDATA_ACK;
                    end
                end

                // Address acknowledge: a read starts sending at once
                tcs_pkg::TCS_ADDR_ACK: begin
                    if (p_fall) begin
                        next_s.sda_oe = 1'b0;
                        if (s.rw) begin
                            load_rd = 1'b1;
                        end else begin
                            next_s.state = tcs_pkg::TCS_REG;
                        end
                    end
                end

                // Pointer or data acknowledge, then more data may follow
                tcs_pkg::TCS_REG_ACK, tcs_pkg::TCS_WDATA_ACK: begin
                    if (p_fall) begin
                        next_s.sda_oe = 1'b0;
                        next_s.state = tcs_pkg::TCS_WDATA;
                    end
                end

                // Read data: one bit per clock fall, most significant first
                tcs_pkg::TCS_RDATA: begin
                    if (p_fall) begin
                        // Eighth bit done: let go for the master's acknowledge
                        if (s.cnt == `TCS_BITS_PER_BYTE) begin
                            next_s.sda_oe = 1'b0;
                            next_s.state = tcs_pkg::TCS_RACK;
                        end else begin
                            next_s.shift = {s.shift[6:0], 1'b0};
                            next_s.sda_oe = ~s.shift[6];
                            next_s.cnt = s.cnt + 4'h1;
                        end
                    end
                end

                // Master acknowledge after a read byte
                tcs_pkg::TCS_RACK: begin
                    if (p_rise) begin
                        next_s.nack = p_sda;
                    end else if (p_fall) begin
                        // A nack ends the read; an ack fetches the next register
                        if (s.nack) begin
                            next_s.state = tcs_pkg::TCS_IDLE;
                        end else begin
                            load_rd = 1'b1;
                        end
                    end
                end

                // Illegal code: fall back to idle
                default: begin
                    next_s.state = tcs_pkg::TCS_IDLE;
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end

        // Load a read byte, drive its first bit, advance the pointer
        if (load_rd) begin
            next_s.shift = rd_byte;
            next_s.sda_oe = ~rd_byte[7];
            next_s.cnt = 4'h1;
            next_s.ptr = s.ptr + 8'h01;
            next_s.state = tcs_pkg::TCS_RDATA;
            rd_clr = (s.ptr == `TCS_OFS_EVENT);
        end

        // Latched events: a new set beats a read clear; bit 2 is never stored
        next_s.events = ((rd_clr ? 8'h00 : s.events) | ev_set) & `TCS_EVT_LATCH_MASK;

        // Input history for the edge detectors and the live fault bit
        next_s.flt_prev = fault_lvl;
        next_s.fault_d = fault_live;
        next_s.attached_d = port_attached;

        // Live connection status, one cycle behind the inputs
        next_s.status = status_view;

        // Interrupt pin: latched events only, fault-present bit excluded
        next_s.irq_o = 1'b0;
        next_s.irq_oe = ~s.control[`TCS_CTRL_MASK]
                        & (|(next_s.events & `TCS_EVT_LATCH_MASK));

        // Both open-drain pins only ever pull low
        next_s.sda_o = 1'b0;
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= reset_value;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Outputs straight from flops
    assign sda_o = s.sda_o;
    assign sda_oe = s.sda_oe;
    assign event_irq_n_o = s.irq_o;
    assign event_irq_n_oe = s.irq_oe;

endmodule

/* dv/tcs_host.sv */
`timescale 1ns/10ps
`include "tcs_regs.svh"

module tcs_host (
    // Clock
    input wire logic clock,
    // Bus wire level and master drives, 1 = released
    input wire logic sda_w,
    output logic scl,
    output logic sda_m
);
    localparam int Q = 8;

    // Bus released at time zero
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // Wait a number of clocks
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Start or repeated start, leaves the clock low
    task automatic start();
        tk(Q);
        sda_m <= 1'b1;
        tk(Q);
        scl <= 1'b1;
        tk(Q);
        sda_m <= 1'b0;
        tk(Q);
        scl <= 1'b0;
    endtask

    // Stop condition, leaves the bus idle
    task automatic stop();
        tk(Q);
        sda_m <= 1'b0;
        tk(Q);
        scl <= 1'b1;
        tk(Q);
        sda_m <= 1'b1;
        tk(Q);
    endtask

    // One bit: data set while the clock is low, wire sampled just before the fall
    task automatic bx(input logic v, output logic r);
        tk(Q);
        sda_m <= v;
        tk(Q);
        scl <= 1'b1;
        tk(Q);
        r = sda_w;
        scl <= 1'b0;
    endtask

    // Eight bits MSB first plus the ninth bit; returns what the wire showed
    task automatic xb(input logic [7:0] d, input logic n, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bx(d[i], q[i]);
        end
        bx(n, a);
    endtask

    // Register read: pointer write, repeated start, one byte then a nack
    task automatic rd(input logic [6:0] id, input logic [7:0] p, output logic [7:0] q,
                      output logic a);
        logic [7:0] z;
        logic y;
        start();
        xb({id, 1'b0}, 1'b1, z, a);
        xb(p, 1'b1, z, y);
        start();
        xb({id, 1'b1}, 1'b1, z, y);
        xb(8'hFF, 1'b1, q, y);
        stop();
    endtask

    // Register write: address, pointer, one data byte
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] z;
        logic y;
        start();
        xb({`TCS_I2C_ADDR, 1'b0}, 1'b1, z, y);
        xb(p, 1'b1, z, y);
        xb(d, 1'b1, z, y);
        stop();
    endtask

    // Two-byte read from one pointer: master acks the first byte, nacks the second
    task automatic rd2(input logic [7:0] p, output logic [7:0] q0, output logic [7:0] q1);
        logic [7:0] z;
        logic y;
        start();
        xb({`TCS_I2C_ADDR, 1'b0}, 1'b1, z, y);
        xb(p, 1'b1, z, y);
        start();
        xb({`TCS_I2C_ADDR, 1'b1}, 1'b1, z, y);
        xb(8'hFF, 1'b0, q0, y);
        xb(8'hFF, 1'b1, q1, y);
        stop();
    endtask
endmodule

/* dv/tcs_event_status_assertions.sv */
`timescale 1ns/10ps

module tcs_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Interrupt pin
    input wire logic event_irq_n_o,
    input wire logic event_irq_n_oe,
    // Event sources
    input wire logic vconn_overcurrent_event,
    input wire logic vconn_overvoltage_event,
    input wire logic vconn_overtemp_event,
    input wire logic port_attached
);
    logic [2:0] flt;
    logic [3:0] prev;
    logic [3:0] hi_cnt;
    logic scl_q, sda_q, busy, cause;

    // A new fault, an attach change or a full recovery
    assign flt = {vconn_overcurrent_event, vconn_overvoltage_event, vconn_overtemp_event};
    assign cause = |(flt & ~prev[2:0]) || port_attached != prev[3] || (|prev[2:0] && ~|flt);

    // Input history, bus activity between start and stop, clock-high length
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prev <= 4'h0;
            busy <= 1'b0;
            hi_cnt <= 4'h0;
        end else begin
            prev <= {port_attached, flt};
            if (scl_i && scl_q && sda_q != sda_i) begin
                busy <= sda_q;
            end
            hi_cnt <= !scl_i ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hF};
        end
        scl_q <= scl_i;
        sda_q <= sda_i;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_drive_zero: assert property (sda_o == 1'b0 && event_irq_n_o == 1'b0)
        else $error("pin drive value not low");
    a_reset_quiet: assert property (
        disable iff (1'b0) !rst_n |=> !sda_oe && !event_irq_n_oe)
        else $error("pins driven during reset");
    a_reset_exit: assert property (
        disable iff (1'b0) $rose(rst_n) |-> !sda_oe && !event_irq_n_oe)
        else $error("pins driven right after reset");
    a_irq_cause: assert property ($rose(event_irq_n_oe) && !busy |-> $past(cause))
        else $error("interrupt raised without an event");
    a_irq_hold: assert property ($fell(event_irq_n_oe) |-> busy)
        else $error("interrupt released without a bus access");
    a_sda_busy: assert property (sda_oe |-> busy)
        else $error("data driven outside a transfer");
    a_sda_stable: assert property (hi_cnt > 4'h5 |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    a_sda_lowscl: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i, 2))
        else $error("data drive changed too soon after clock fall");

    c_irq_set: cover property ($rose(event_irq_n_oe));
    c_irq_clr: cover property ($fell(event_irq_n_oe));
    c_ack: cover property ($rose(sda_oe));
endmodule

bind tcs_event_status tcs_chk tcs_chk_i (
    .clock(clock), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .event_irq_n_o(event_irq_n_o), .event_irq_n_oe(event_irq_n_oe),
    .vconn_overcurrent_event(vconn_overcurrent_event),
    .vconn_overvoltage_event(vconn_overvoltage_event),
    .vconn_overtemp_event(vconn_overtemp_event), .port_attached(port_attached)
);

/* dv/tb_typec_event_and_connection_status_regs.sv */
`timescale 1ns/10ps
`include "tcs_regs.svh"

module tb_typec_event_and_connection_status_regs;
    localparam logic [7:0] EB [3] = '{8'h08, 8'h20, 8'h40};
    logic clock, rst_n, ce, scl, sda_m, sda_w, sda_o, sda_oe, irq_o, irq_oe, irq_w;
    logic att, sink, vbus, a;
    logic [1:0] cur, orient;
    logic [2:0] flt, ptype;
    logic [7:0] d, d2;
    integer seed, r;
    int fail_count = 0;
    int compares = 0;

    // Wired levels: pull-ups unless someone pulls low
    assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
    assign irq_w = irq_oe ? irq_o : 1'b1;

    tcs_event_status tcs_event_status_i (
        .clock(clock), .rst_n(rst_n), .ce(ce), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .event_irq_n_o(irq_o), .event_irq_n_oe(irq_oe),
        .vconn_overcurrent_event(flt[2]), .vconn_overvoltage_event(flt[1]),
        .vconn_overtemp_event(flt[0]), .port_attached(att), .role_is_sink(sink),
        .vbus_present(vbus), .adv_current(cur), .partner_type(ptype), .plug_orient(orient)
    );
    tcs_host tcs_host_i (.clock(clock), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));

    // Free-running 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Compare and count
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // Counts and verdict
    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Register read at the device address with ack checked
    task automatic rdr(input logic [7:0] p, input logic [7:0] e);
        tcs_host_i.rd(`TCS_I2C_ADDR, p, d, a);
        chk("ack", {7'h00, a}, 8'h00);
        chk("register", d, e);
    endtask

    // Interrupt wire level a few clocks on, sampled off the edge
    task automatic irq_chk(input logic e);
        repeat (3) @(posedge clock);
        #1;
        chk("irq_n", {7'h00, irq_w}, {7'h00, e});
    endtask

    // Expected connection status from the live inputs
    function automatic logic [7:0] exp_st();
        exp_st = {vbus & (sink | ptype == 3'h3 | ptype == 3'h4), sink ? cur : 2'h0, ptype, orient};
    endfunction

    // Reset, then directed and random scenarios
    initial begin
        seed = 32'hA9EE;
        {rst_n, flt, att, sink, vbus, cur, ptype, orient} = '0;
        ce = 1'b1;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 1; i < 8; i++) rdr(8'(i), 8'h00);
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            flt[k] <= 1'b1;
            irq_chk(1'b0);
            rdr(8'h03, EB[k] | 8'h04);
            irq_chk(1'b1);
            rdr(8'h03, 8'h04);
            @(posedge clock);
            flt[k] <= 1'b0;
            irq_chk(1'b0);
            rdr(8'h03, 8'h80);
            rdr(8'h03, 8'h00);
        end
        // Overlapping faults: no recovery until all are gone
        @(posedge clock);
        flt <= 3'h6;
        repeat (5) @(posedge clock);
        flt <= 3'h4;
        rdr(8'h03, 8'h64);
        @(posedge clock);
        flt <= 3'h0;
        rdr(8'h03, 8'h80);
        // Attach then detach back to back, then each alone
        @(posedge clock);
        att <= 1'b1;
        repeat (4) @(posedge clock);
        att <= 1'b0;
        irq_chk(1'b0);
        rdr(8'h03, 8'h03);
        @(posedge clock);
        att <= 1'b1;
        rdr(8'h03, 8'h01);
        @(posedge clock);
        att <= 1'b0;
        rdr(8'h03, 8'h02);
        // Masked event keeps the pin released until unmasked
        tcs_host_i.wr(8'h02, 8'h01);
        rdr(8'h02, 8'h01);
        @(posedge clock);
        flt[1] <= 1'b1;
        irq_chk(1'b1);
        tcs_host_i.wr(8'h02, 8'h00);
        irq_chk(1'b0);
        rdr(8'h03, 8'h24);
        @(posedge clock);
        flt[1] <= 1'b0;
        rdr(8'h03, 8'h80);
        // Wrong device address is not acknowledged
        tcs_host_i.rd(7'h2A, 8'h03, d, a);
        chk("nack", {7'h00, a}, 8'h01);
        // Status: write to read-only byte ignored, all partner types, random rest
        tcs_host_i.wr(8'h04, 8'hFF);
        rdr(8'h02, 8'h00);
        for (int n = 0; n < 12; n++) begin
            r = $random(seed);
            @(posedge clock);
            {vbus, sink, cur, orient} <= r[5:0];
            ptype <= (n < 5) ? 3'(n) : 3'(r[15:8] % 5);
            @(posedge clock);
            rdr(8'h04, exp_st());
        end
        // Two-byte read with master acknowledge: event byte, then the status byte
        @(posedge clock);
        att <= 1'b1;
        repeat (3) @(posedge clock);
        tcs_host_i.rd2(8'h03, d, d2);
        chk("event", d, 8'h01);
        chk("status", d2, exp_st());
        // Frozen while clock enable is low: a detach and re-attach go unseen
        @(posedge clock);
        ce <= 1'b0;
        att <= 1'b0;
        repeat (4) @(posedge clock);
        att <= 1'b1;
        repeat (2) @(posedge clock);
        ce <= 1'b1;
        rdr(8'h03, 8'h00);
        test_done();
    end

    // Run limit
    initial begin
        repeat (90000) @(posedge clock);
        fail_count++;
        test_done();
    end
endmodule
